// *** rtl/gpio_regs.svh ***
// register addresses, reset values and field positions of the port block
`ifndef GPIO_REGS_SVH
`define GPIO_REGS_SVH

// special-function register addresses
`define PORT0_PIN_DATA_ADDR        8'h80
`define PORT1_PIN_DATA_ADDR        8'h90
`define PORT0_DIRECTION_ADDR       8'h94
`define PORT0_FUNCTION_SELECT_ADDR 8'h95
`define PORT1_DIRECTION_ADDR       8'h96
`define PORT1_FUNCTION_SELECT_ADDR 8'h97
`define SPI_ROUTE_ADDR             8'hB3

// widths
`define PORT0_WIDTH     8
`define PORT1_WIDTH     3
`define SPI_ROUTE_WIDTH 2

// reset values, cut to each register's width
`define PORT0_DATA_RESET     8'hFF
`define PORT0_DIR_RESET      8'hFF
`define PORT0_FUNC_RESET     8'h00
`define PORT1_DATA_RESET     3'h7
`define PORT1_DIR_RESET      3'h7
`define PORT1_FUNC_RESET     3'h0
`define SPI_ROUTE_RESET      2'h0

// spi routing codes
`define SPI_ROUTE_UNUSED     2'h0
`define SPI_ROUTE_PORT1      2'h1
`define SPI_ROUTE_RADIO      2'h2

// port 0 bit positions
`define P0_BOOT_SELECT_BIT   0
`define P0_UART_RX_BIT       1
`define P0_UART_TX_BIT       2
`define P0_IRQ_A_BIT         3
`define P0_IRQ_B_BIT         4
`define P0_TIMER_A_BIT       5
`define P0_TIMER_B_BIT       6
`define P0_PWM_BIT           7

// port 1 bit positions
`define P1_SCK_BIT           0
`define P1_SDO_BIT           1
`define P1_SDI_BIT           2
`define P1_TIMER_C_BIT       0

// direction encoding: 0 drives, 1 listens
`define DIR_OUTPUT           1'h0

`endif

// *** rtl/gpio_pkg.sv ***
// types shared by the port block and its helpers
package gpio_pkg;

  // drive of the eight port 0 pins
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } port0_drive_type;

  // drive of the two bidirectional port 1 pins
  typedef struct packed {
    logic [1:0] out;
    logic [1:0] oe;
  } port1_drive_type;

  // signals coming from the peripherals into the pin mux
  typedef struct packed {
    logic uart_txd;
    logic uart_rxd_out;
    logic pwm;
    logic spi_sck;
    logic spi_sdo;
    logic radio_sdi;
  } periph_in_type;

  // signals handed from the pin mux to the peripherals
  typedef struct packed {
    logic uart_rxd;
    logic ext_irq_a_n;
    logic ext_irq_b_n;
    logic timer_a_count_in;
    logic timer_b_count_in;
    logic timer_c_count_in;
    logic spi_sdi;
    logic radio_sck;
    logic radio_sdo;
  } periph_out_type;

endpackage

// *** rtl/pin_sync.sv ***
// three-stage input synchroniser that accepts a change once stages two and three agree
`timescale 1ns/100ps
module pin_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] raw,
  output logic      [WIDTH-1:0] level
);

  logic [WIDTH-1:0] stage_one;        // only stage_two reads this
  logic [WIDTH-1:0] stage_two;        // second flop
  logic [WIDTH-1:0] stage_three;      // third flop
  logic [WIDTH-1:0] next_level;       // accepted value

  // per bit, take the new value only where two and three agree
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      next_level[i] = (stage_two[i] == stage_three[i]) ? stage_three[i] : level[i];
    end
  end

  // pins idle high through pull-ups, so all stages start at one
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stage_one   <= '1;
      stage_two   <= '1;
      stage_three <= '1;
      level       <= '1;
    end else begin
      stage_one   <= raw;
      stage_two   <= stage_one;
      stage_three <= stage_two;
      level       <= next_level;
    end
  end

endmodule

// *** rtl/data_reg.sv ***
// one software-written register with a fixed reset value
`timescale 1ns/100ps
module data_reg #(
  parameter int                 WIDTH       = 8,
  parameter logic [WIDTH-1:0]   RESET_VALUE = '0
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic             wr_en,
  input  wire logic [WIDTH-1:0] wr_data,
  output logic      [WIDTH-1:0] value
);

  logic [WIDTH-1:0] next_value;       // value after this edge

  // hold unless written
  always_comb begin
    next_value = wr_en ? wr_data : value;
  end

  // reset loads the documented constant
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      value <= RESET_VALUE;
    end else begin
      value <= next_value;
    end
  end

endmodule

// *** rtl/dual_port_gpio_with_pin_mux.sv ***
// two-port pin logic with alternate-function and spi routing
`timescale 1ns/100ps
`include "gpio_regs.svh"

module dual_port_gpio_with_pin_mux (
  input  wire logic                   ref_clk,
  input  wire logic                   rst,
  // special-function register port of the controller
  input  wire logic [7:0]             sfr_addr,
  input  wire logic                   sfr_wr,
  input  wire logic                   sfr_rd,
  input  wire logic [7:0]             sfr_wdata,
  output logic      [7:0]             sfr_rdata,
  output logic                        sfr_hit,
  // port 0 pins, bidir_pin_two .. bidir_pin_nine
  input  wire logic [7:0]             port0_pin_in,
  output gpio_pkg::port0_drive_type   port0_pin,
  // port 1: bidir_pin_zero, bidir_pin_one, input_only_pin
  input  wire logic [2:0]             port1_pin_in,
  output gpio_pkg::port1_drive_type   port1_pin,
  // peripheral side
  input  wire gpio_pkg::periph_in_type periph_in,
  output gpio_pkg::periph_out_type    periph_out,
  output logic [1:0]                  spi_route
);

  //////////////////////////////////////////////////////////////////////////////
  // register decode

  logic wr_p0_data;                   // write strobe, port0 data latch
  logic wr_port0_direction;                    // write strobe, port0 direction
  logic wr_p0_func;                   // write strobe, port0 function select
  logic wr_p1_data;                   // write strobe, port1 data latch
  logic wr_port1_direction;                    // write strobe, port1 direction
  logic wr_p1_func;                   // write strobe, port1 function select
  logic wr_route;                     // write strobe, spi routing

  // one strobe per address, only while writing
  always_comb begin
    wr_p0_data = sfr_wr && (sfr_addr == `PORT0_PIN_DATA_ADDR);
    wr_port0_direction  = sfr_wr && (sfr_addr == `PORT0_DIRECTION_ADDR);
    wr_p0_func = sfr_wr && (sfr_addr == `PORT0_FUNCTION_SELECT_ADDR);
    wr_p1_data = sfr_wr && (sfr_addr == `PORT1_PIN_DATA_ADDR);
    wr_port1_direction  = sfr_wr && (sfr_addr == `PORT1_DIRECTION_ADDR);
    wr_p1_func = sfr_wr && (sfr_addr == `PORT1_FUNCTION_SELECT_ADDR);
    wr_route   = sfr_wr && (sfr_addr == `SPI_ROUTE_ADDR);
  end

  //////////////////////////////////////////////////////////////////////////////
  // registers

  logic [7:0] port0_latch;            // port0 output latch
  logic [7:0] port0_direction;        // 0 drives, 1 listens
  logic [7:0] port0_function_select;  // alternate function enables
  logic [2:0] port1_latch;            // port1 output latch, three bits only
  logic [2:0] port1_direction;        // port1 direction, three bits only
  logic [2:0] port1_function_select;  // port1 alternate enables
  logic [1:0] route;                  // spi routing field

  // direction and data reset to ones, so every pin listens after reset
  data_reg #(.WIDTH(`PORT0_WIDTH), .RESET_VALUE(`PORT0_DATA_RESET)) u_p0_data (
    .ref_clk (ref_clk),
    .rst     (rst),
    .wr_en   (wr_p0_data),
    .wr_data (sfr_wdata),
    .value   (port0_latch)
  );

  data_reg #(.WIDTH(`PORT0_WIDTH), .RESET_VALUE(`PORT0_DIR_RESET)) u_port0_direction (
    .ref_clk (ref_clk),
    .rst     (rst),
    .wr_en   (wr_port0_direction),
    .wr_data (sfr_wdata),
    .value   (port0_direction)
  );

  data_reg #(.WIDTH(`PORT0_WIDTH), .RESET_VALUE(`PORT0_FUNC_RESET)) u_p0_func (
    .ref_clk (ref_clk),
    .rst     (rst),
    .wr_en   (wr_p0_func),
    .wr_data (sfr_wdata),
    .value   (port0_function_select)
  );

  // upper five data bits are dropped on write and read as zero
  data_reg #(.WIDTH(`PORT1_WIDTH), .RESET_VALUE(`PORT1_DATA_RESET)) u_p1_data (
    .ref_clk (ref_clk),
    .rst     (rst),
    .wr_en   (wr_p1_data),
    .wr_data (sfr_wdata[2:0]),
    .value   (port1_latch)
  );

  data_reg #(.WIDTH(`PORT1_WIDTH), .RESET_VALUE(`PORT1_DIR_RESET)) u_port1_direction (
    .ref_clk (ref_clk),
    .rst     (rst),
    .wr_en   (wr_port1_direction),
    .wr_data (sfr_wdata[2:0]),
    .value   (port1_direction)
  );

  data_reg #(.WIDTH(`PORT1_WIDTH), .RESET_VALUE(`PORT1_FUNC_RESET)) u_p1_func (
    .ref_clk (ref_clk),
    .rst     (rst),
    .wr_en   (wr_p1_func),
    .wr_data (sfr_wdata[2:0]),
    .value   (port1_function_select)
  );

  // code 11 is stored as written; it routes nowhere
  data_reg #(.WIDTH(`SPI_ROUTE_WIDTH), .RESET_VALUE(`SPI_ROUTE_RESET)) u_route (
    .ref_clk (ref_clk),
    .rst     (rst),
    .wr_en   (wr_route),
    .wr_data (sfr_wdata[1:0]),
    .value   (route)
  );

  //////////////////////////////////////////////////////////////////////////////
  // pin input synchronisers

  logic [7:0] port0_level;            // filtered port0 pin levels
  logic [2:0] port1_level;            // filtered port1 pin levels

  // pins belong to the board, not to ref_clk
  pin_sync #(.WIDTH(`PORT0_WIDTH)) u_sync0 (
    .ref_clk (ref_clk),
    .rst     (rst),
    .raw     (port0_pin_in),
    .level   (port0_level)
  );

  pin_sync #(.WIDTH(`PORT1_WIDTH)) u_sync1 (
    .ref_clk (ref_clk),
    .rst     (rst),
    .raw     (port1_pin_in),
    .level   (port1_level)
  );

  //////////////////////////////////////////////////////////////////////////////
  // port 0 mux

  gpio_pkg::port0_drive_type next_port0_pin;   // drive before the output flop

  // plain gpio first, then alternate functions override bit by bit
  always_comb begin
    for (int n = 0; n < `PORT0_WIDTH; n++) begin
      next_port0_pin.out[n] = port0_latch[n];
      next_port0_pin.oe[n]  = (port0_direction[n] == `DIR_OUTPUT);
    end
    // bit 0 skips this block: boot flash select stays gpio
    if (port0_function_select[`P0_UART_RX_BIT]) begin
      // receive pin may drive in shift mode, but direction bit decides
      next_port0_pin.out[`P0_UART_RX_BIT] = periph_in.uart_rxd_out;
      next_port0_pin.oe[`P0_UART_RX_BIT]  =
        (port0_direction[`P0_UART_RX_BIT] == `DIR_OUTPUT);
    end
    if (port0_function_select[`P0_UART_TX_BIT]) begin
      next_port0_pin.out[`P0_UART_TX_BIT] = periph_in.uart_txd;
      next_port0_pin.oe[`P0_UART_TX_BIT]  = 1'b1;
    end
    if (port0_function_select[`P0_IRQ_A_BIT]) begin
      next_port0_pin.oe[`P0_IRQ_A_BIT] = 1'b0;
    end
    if (port0_function_select[`P0_IRQ_B_BIT]) begin
      next_port0_pin.oe[`P0_IRQ_B_BIT] = 1'b0;
    end
    if (port0_function_select[`P0_TIMER_A_BIT]) begin
      next_port0_pin.oe[`P0_TIMER_A_BIT] = 1'b0;
    end
    if (port0_function_select[`P0_TIMER_B_BIT]) begin
      next_port0_pin.oe[`P0_TIMER_B_BIT] = 1'b0;
    end
    if (port0_function_select[`P0_PWM_BIT]) begin
      next_port0_pin.out[`P0_PWM_BIT] = periph_in.pwm;
      next_port0_pin.oe[`P0_PWM_BIT]  = 1'b1;
    end
    // port0_function_select bit 0 is stored but never looked at here
  end

  //////////////////////////////////////////////////////////////////////////////
  // port 1 mux

  gpio_pkg::port1_drive_type next_port1_pin;   // drive before the output flop
  logic                      spi_on_port1;     // route selects the pins

  // spi route outranks function select, which outranks direction
  always_comb begin
    spi_on_port1 = (route == `SPI_ROUTE_PORT1);
    // gpio defaults; bit 1 has no function-select alternate, only the spi route takes it over
    next_port1_pin.out[0] = port1_latch[0];
    next_port1_pin.oe[0]  = (port1_direction[0] == `DIR_OUTPUT);
    next_port1_pin.out[1] = port1_latch[1];
    next_port1_pin.oe[1]  = (port1_direction[1] == `DIR_OUTPUT);
    if (spi_on_port1) begin
      next_port1_pin.out[`P1_SCK_BIT] = periph_in.spi_sck;
      next_port1_pin.oe[`P1_SCK_BIT]  = 1'b1;
      next_port1_pin.out[`P1_SDO_BIT] = periph_in.spi_sdo;
      next_port1_pin.oe[`P1_SDO_BIT]  = 1'b1;
    end else if (port1_function_select[`P1_TIMER_C_BIT]) begin
      next_port1_pin.oe[`P1_TIMER_C_BIT] = 1'b0;
    end
    // bit 2 has no driver at all in this block
  end

  //////////////////////////////////////////////////////////////////////////////
  // peripheral side

  gpio_pkg::periph_out_type next_periph_out;   // peripheral inputs before flop

  // idle values: interrupts high, counters low, so nothing fires unselected
  always_comb begin
    next_periph_out.uart_rxd = port0_function_select[`P0_UART_RX_BIT] ?
                               port0_level[`P0_UART_RX_BIT] : 1'b1;
    next_periph_out.ext_irq_a_n = port0_function_select[`P0_IRQ_A_BIT] ?
                                  port0_level[`P0_IRQ_A_BIT] : 1'b1;
    next_periph_out.ext_irq_b_n = port0_function_select[`P0_IRQ_B_BIT] ?
                                  port0_level[`P0_IRQ_B_BIT] : 1'b1;
    next_periph_out.timer_a_count_in = port0_function_select[`P0_TIMER_A_BIT] &
                                       port0_level[`P0_TIMER_A_BIT];
    next_periph_out.timer_b_count_in = port0_function_select[`P0_TIMER_B_BIT] &
                                       port0_level[`P0_TIMER_B_BIT];
    next_periph_out.timer_c_count_in = !spi_on_port1 &&
                                       port1_function_select[`P1_TIMER_C_BIT] &&
                                       port1_level[`P1_TIMER_C_BIT];
    // serial input follows whichever side the route selects
    case (route)
      `SPI_ROUTE_PORT1: next_periph_out.spi_sdi = port1_level[`P1_SDI_BIT];
      `SPI_ROUTE_RADIO: next_periph_out.spi_sdi = periph_in.radio_sdi;
      default:          next_periph_out.spi_sdi = 1'b0;
    endcase
    // radio only sees clock and data while routed to it
    next_periph_out.radio_sck = (route == `SPI_ROUTE_RADIO) & periph_in.spi_sck;
    next_periph_out.radio_sdo = (route == `SPI_ROUTE_RADIO) & periph_in.spi_sdo;
  end

  //////////////////////////////////////////////////////////////////////////////
  // read data

  logic [7:0] next_sfr_rdata;         // read value before the flop
  logic       next_sfr_hit;           // address belongs to this block

  // data reads mix latch and pin per registered drive enable of each bit
  always_comb begin
    next_sfr_hit   = 1'b1;
    next_sfr_rdata = 8'h00;
    case (sfr_addr)
      `PORT0_PIN_DATA_ADDR: begin
        for (int n = 0; n < `PORT0_WIDTH; n++) begin
          next_sfr_rdata[n] = port0_pin.oe[n] ? port0_latch[n] : port0_level[n];
        end
      end
      `PORT1_PIN_DATA_ADDR: begin
        next_sfr_rdata[0] = port1_pin.oe[0] ? port1_latch[0] : port1_level[0];
        next_sfr_rdata[1] = port1_pin.oe[1] ? port1_latch[1] : port1_level[1];
        next_sfr_rdata[2] = port1_level[2];
      end
      `PORT0_DIRECTION_ADDR:       next_sfr_rdata = port0_direction;
      `PORT0_FUNCTION_SELECT_ADDR: next_sfr_rdata = port0_function_select;
      `PORT1_DIRECTION_ADDR:       next_sfr_rdata = {5'h00, port1_direction};
      `PORT1_FUNCTION_SELECT_ADDR: next_sfr_rdata = {5'h00, port1_function_select};
      `SPI_ROUTE_ADDR:             next_sfr_rdata = {6'h00, route};
      default:                     next_sfr_hit   = 1'b0;
    endcase
    if (!sfr_rd) begin
      next_sfr_hit   = 1'b0;
      next_sfr_rdata = 8'h00;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // output flops

  // async reset clears every enable even with the clock stopped
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      port0_pin  <= '0;
      port1_pin  <= '0;
      periph_out <= '{uart_rxd: 1'b1, ext_irq_a_n: 1'b1, ext_irq_b_n: 1'b1,
                      default: 1'b0};
      spi_route  <= `SPI_ROUTE_RESET;
      sfr_rdata  <= 8'h00;
      sfr_hit    <= 1'b0;
    end else begin
      // registers reset to listen, so pins stay inputs until written
      port0_pin  <= next_port0_pin;
      port1_pin  <= next_port1_pin;
      periph_out <= next_periph_out;
      spi_route  <= route;
      sfr_rdata  <= next_sfr_rdata;
      sfr_hit    <= next_sfr_hit;
    end
  end

endmodule

// *** dv/gpio_props.sv ***
// concurrent checks on the ports of the two-port pin block
`timescale 1ns/100ps
module gpio_props (
  input  wire logic                     ref_clk,
  input  wire logic                     rst,
  input  wire logic [7:0]               sfr_addr,
  input  wire logic                     sfr_wr,
  input  wire logic                     sfr_rd,
  input  wire logic [7:0]               sfr_wdata,
  input  wire logic [7:0]               sfr_rdata,
  input  wire logic                     sfr_hit,
  input  wire logic [7:0]               port0_pin_in,
  input  wire gpio_pkg::port0_drive_type port0_pin,
  input  wire logic [2:0]               port1_pin_in,
  input  wire gpio_pkg::port1_drive_type port1_pin,
  input  wire gpio_pkg::periph_in_type  periph_in,
  input  wire gpio_pkg::periph_out_type periph_out,
  input  wire logic [1:0]               spi_route
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////
  // shadow copies of the registers except the port1 data latch, rebuilt from the write strobes only
  logic [7:0] data0, dir0, sel0, next_data0, next_dir0, next_sel0, eoe0, eout0, erd;
  logic [2:0] dir1, sel1, next_dir1, next_sel1;
  logic [1:0] route, next_route, eoe1;
  logic       map_hit; // address decodes to a register
  // next shadow values; upper bits of narrow registers fall away
  always_comb begin
    {next_data0, next_dir0, next_sel0} = {data0, dir0, sel0};
    {next_dir1, next_sel1, next_route} = {dir1, sel1, route};
    if (sfr_wr) begin
      case (sfr_addr)
        8'h80: next_data0 = sfr_wdata;
        8'h94: next_dir0 = sfr_wdata;
        8'h95: next_sel0 = sfr_wdata;
        8'h96: next_dir1 = sfr_wdata[2:0];
        8'h97: next_sel1 = sfr_wdata[2:0];
        8'hB3: next_route = sfr_wdata[1:0];
        default: ;  // unmapped writes change nothing
      endcase
    end
  end
  // shadow registers, reset like the device
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      {data0, dir0, sel0} <= {8'hFF, 8'hFF, 8'h00};
      {dir1, sel1, route} <= {3'h7, 3'h0, 2'h0};
    end else begin
      {data0, dir0, sel0} <= {next_data0, next_dir0, next_sel0};
      {dir1, sel1, route} <= {next_dir1, next_sel1, next_route};
    end
  end
  // expected drive and read data from the shadows
  always_comb begin
    eoe0 = ~dir0;
    eoe0[2] = sel0[2] | ~dir0[2];
    eoe0[7] = sel0[7] | ~dir0[7];
    eoe0[6:3] = ~dir0[6:3] & ~sel0[6:3];
    eout0 = data0;
    eout0[1] = sel0[1] ? periph_in.uart_rxd_out : data0[1];
    eout0[2] = sel0[2] ? periph_in.uart_txd : data0[2];
    eout0[7] = sel0[7] ? periph_in.pwm : data0[7];
    eoe1 = (route == 2'h1) ? 2'h3 : {~dir1[1], ~dir1[0] & ~sel1[0]};
    map_hit = sfr_addr inside {8'h80, 8'h90, 8'h94, 8'h95, 8'h96, 8'h97, 8'hB3};
    case (sfr_addr)
      8'h94:   erd = dir0;
      8'h95:   erd = sel0;
      8'h96:   erd = {5'h00, dir1};
      8'h97:   erd = {5'h00, sel1};
      8'hB3:   erd = {6'h00, route};
      default: erd = 8'h00;
    endcase
  end
  // data reads depend on pins, so only configuration reads are compared
  sequence cfg_read;
    sfr_rd && sfr_addr != 8'h80 && sfr_addr != 8'h90;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  release_idle_a: assert property ($past(rst) |-> port0_pin.oe == 8'h00 && port1_pin.oe == 2'h0)
    else $error("pin driven at reset release");
  p0_low_dir_a: assert property (port0_pin.oe[1:0] == ~$past(dir0[1:0]))
    else $error("port0 bit0/1 drive not from direction");
  port0_function_select_oe_a: assert property (port0_pin.oe[7:2] == $past(eoe0[7:2]))
    else $error("port0 drive enable wrong");
  port0_function_select_out_a: assert property ((port0_pin.out & port0_pin.oe) == ($past(eout0) & port0_pin.oe))
    else $error("port0 driven level wrong");
  p1_oe_a: assert property (port1_pin.oe == $past(eoe1))
    else $error("port1 drive enable wrong");
  spi_out_a: assert property ($past(route) == 2'h1 |->
    port1_pin.out == $past({periph_in.spi_sdo, periph_in.spi_sck}))
    else $error("spi lines not on port1");
  irq_gate_a: assert property (($past(sel0[3]) || periph_out.ext_irq_a_n) &&
    ($past(sel0[4]) || periph_out.ext_irq_b_n))
    else $error("interrupt passed while unselected");
  route_idle_a: assert property ($past(route) inside {2'h0, 2'h3} |->
    !periph_out.spi_sdi && !periph_out.radio_sck)
    else $error("spi lines active while unused");
  radio_pass_a: assert property ($past(route) == 2'h2 |->
    periph_out.radio_sck == $past(periph_in.spi_sck) &&
    periph_out.spi_sdi == $past(periph_in.radio_sdi))
    else $error("radio routing wrong");
  read_value_a: assert property (cfg_read |=> sfr_rdata == $past(erd))
    else $error("register read value wrong");
  read_hit_a: assert property (sfr_hit == $past(sfr_rd && map_hit))
    else $error("read hit flag wrong");
  route_copy_a: assert property (spi_route == $past(route))
    else $error("route copy output wrong");
endmodule

// *** dv/pin_model.sv ***
// board model: wire levels of both ports plus one spi slave
`timescale 1ns/100ps
module pin_model (
  input  wire gpio_pkg::port0_drive_type port0_pin,
  input  wire gpio_pkg::port1_drive_type port1_pin,
  input  wire logic [7:0]               board0,
  input  wire logic [2:0]               board1,
  output logic      [7:0]               port0_pin_in,
  output logic      [2:0]               port1_pin_in
);
  logic slave_sel_n; // slave select, a plain port0 gpio wire
  // wire levels: the driving party wins, else the board level
  always_comb begin
    port0_pin_in = (port0_pin.out & port0_pin.oe) | (board0 & ~port0_pin.oe);
    port1_pin_in[1:0] = (port1_pin.out & port1_pin.oe) | (board1[1:0] & ~port1_pin.oe);
    slave_sel_n = port0_pin_in[5];
    // selected slave answers the inverse of the data line, so it never echoes
    port1_pin_in[2] = slave_sel_n ? board1[2] : ~port1_pin_in[1];
  end
endmodule

// *** dv/dual_port_gpio_with_pin_mux_tb.sv ***
// self-checking bench of the two-port pin block
`timescale 1ns/100ps
module dual_port_gpio_with_pin_mux_tb;
  logic                      ref_clk, rst, sfr_wr, sfr_rd, sfr_hit;
  logic [7:0]                sfr_addr, sfr_wdata, sfr_rdata, port0_pin_in, board0;
  logic [2:0]                port1_pin_in, board1;
  logic [1:0]                spi_route;
  gpio_pkg::port0_drive_type port0_pin;
  gpio_pkg::port1_drive_type port1_pin;
  gpio_pkg::periph_in_type   periph_in;
  gpio_pkg::periph_out_type  periph_out;
  int                        failures, samples_checked;
  dual_port_gpio_with_pin_mux uut (.ref_clk(ref_clk), .rst(rst), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .sfr_hit(sfr_hit), .port0_pin_in(port0_pin_in), .port0_pin(port0_pin),
    .port1_pin_in(port1_pin_in), .port1_pin(port1_pin), .periph_in(periph_in),
    .periph_out(periph_out), .spi_route(spi_route));
  pin_model board (.port0_pin(port0_pin), .port1_pin(port1_pin), .board0(board0),
    .board1(board1), .port0_pin_in(port0_pin_in), .port1_pin_in(port1_pin_in));
  ////////////////////////////////////////////////////////////////////////////
  // 100 MHz clock
  initial begin
    ref_clk = 1'h0;
    forever #5 ref_clk = ~ref_clk;
  end
  // one compare for every result, widened to 16 bits
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // register write: strobe held across one rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    {sfr_addr, sfr_wdata, sfr_wr} = {a, d, 1'h1};
    @(negedge ref_clk);
    sfr_wr = 1'h0;
  endtask
  // register read: {hit, data} looked at in the one cycle it stands
  task automatic rd(input logic [7:0] a, input logic [8:0] exp);
    @(negedge ref_clk);
    {sfr_addr, sfr_rd} = {a, 1'h1};
    @(negedge ref_clk);
    sfr_rd = 1'h0;
    chk($sformatf("read %h", a), {7'h00, exp}, {7'h00, sfr_hit, sfr_rdata});
  endtask
  // covers register-to-pin (2) and pin sync (4) latency
  task automatic settle;
    repeat (6) @(negedge ref_clk);
  endtask
  // pin drive, driven levels masked by enable
  task automatic pins(input logic [7:0] oe0, input logic [7:0] out0, input logic [3:0] p1);
    settle();
    chk("port0 oe", {8'h00, oe0}, {8'h00, port0_pin.oe});
    chk("port0 out", {8'h00, out0}, {8'h00, port0_pin.out & port0_pin.oe});
    chk("port1 drive", {12'h000, p1}, {12'h000, port1_pin.oe, port1_pin.out & port1_pin.oe});
  endtask
  // peripheral side of the mux
  task automatic side(input logic [8:0] e);
    settle();
    chk("peripheral side", {7'h00, e}, {7'h00, periph_out});
  endtask
  task automatic done(input string n);
    $display("test %s done", n);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // hang guard
  initial begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    end_sim();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst, sfr_wr, sfr_rd, sfr_addr, sfr_wdata} = {1'h1, 1'h0, 1'h0, 8'h00, 8'h00};
    {board0, board1, periph_in} = {8'h64, 3'h5, 6'h00};
    failures = 0;
    samples_checked = 0;
    repeat (6) @(negedge ref_clk);
    chk("reset oe", 16'h0000, {port0_pin.oe, 6'h00, port1_pin.oe});
    rst = 1'h0;
    settle();
    rd(8'h94, 9'h1FF);
    rd(8'h95, 9'h100);
    rd(8'h96, 9'h107);
    rd(8'h97, 9'h100);
    rd(8'hB3, 9'h100);
    rd(8'h81, 9'h000);
    rd(8'h80, 9'h164);
    rd(8'h90, 9'h105);
    pins(8'h00, 8'h00, 4'h0);
    done("reset");
    // low nibble driven: read mixes latch and pins
    wr(8'h80, 8'hA5);
    wr(8'h94, 8'hF0);
    pins(8'h0F, 8'h05, 4'h0);
    rd(8'h80, 9'h165);
    // transmit and pwm high, receive loopback low
    periph_in = 6'h28;
    wr(8'h94, 8'hFF);
    wr(8'h95, 8'hFF);
    pins(8'h84, 8'h84, 4'h0);
    wr(8'h94, 8'hFC);
    pins(8'h87, 8'h85, 4'h0);
    side(9'h030);
    wr(8'h95, 8'h00);
    side(9'h1C0);
    done("port0");
    // port1 gpio, then timer input on bit0 only
    wr(8'h90, 8'h02);
    wr(8'h96, 8'hFC);
    pins(8'h03, 8'h01, 4'hE);
    rd(8'h96, 9'h104);
    wr(8'h97, 8'h03);
    pins(8'h03, 8'h01, 4'hA);
    side(9'h1C8);
    done("port1");
    // slave selected by port0 bit5, then spi routed to port1
    wr(8'h80, 8'h85);
    wr(8'h94, 8'hDC);
    wr(8'hB3, 8'h01);
    for (int v = 0; v < 2; v++) begin
      periph_in.spi_sdo = v[0];
      periph_in.spi_sck = ~v[0];
      pins(8'h23, 8'h01, {2'h3, v[0], ~v[0]});
      chk("spi data in", {15'h0000, ~v[0]}, {15'h0000, periph_out.spi_sdi});
    end
    periph_in.radio_sdi = 1'h1;
    periph_in.spi_sck = 1'h1;
    for (int r = 0; r < 4; r++) begin
      wr(8'hB3, 8'(r));
      settle();
      chk("route lines", {13'h0000, r == 2, r == 2, r == 2},
          {13'h0000, periph_out.radio_sdo, periph_out.radio_sck, periph_out.spi_sdi});
      chk("route copy", {14'h0000, 2'(r)}, {14'h0000, spi_route});
      rd(8'hB3, {1'h1, 8'(r)});
    end
    done("spi");
    end_sim();
  end
endmodule
bind dual_port_gpio_with_pin_mux gpio_props props (.ref_clk(ref_clk), .rst(rst),
  .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
  .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .port0_pin_in(port0_pin_in),
  .port0_pin(port0_pin), .port1_pin_in(port1_pin_in), .port1_pin(port1_pin),
  .periph_in(periph_in), .periph_out(periph_out), .spi_route(spi_route));
